// ==== rtl/cpu_pc_sp_register_file.sv ====
// Register file with program counter, stack pointer and memory sequencer
`timescale 1ns/1ns
module cpu_pc_sp_register_file (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [regfile_pkg::AW-1:0] paddr,
	input  wire logic [regfile_pkg::DW-1:0] pwdata,
	input  wire logic [3:0]                 pstrb,
	output logic                            pready,
	output logic      [regfile_pkg::DW-1:0] prdata,
	output logic                            pslverr,
	output logic                            mem_req,
	output logic                            mem_we,
	output logic      [regfile_pkg::W-1:0]  mem_addr,
	output logic      [regfile_pkg::W-1:0]  mem_wdata,
	output logic      [1:0]                 mem_ben,
	input  wire logic [regfile_pkg::W-1:0]  mem_rdata,
	input  wire logic                       mem_ack
);
	import regfile_pkg::*;

	logic [W-1:0] regs_q [NREG];  // Register array
	logic [W-1:0] regs_d [NREG];  // Next register values
	logic [W-1:0] pc_even;        // Aligned next counter
	logic [W-1:0] sp_even;        // Aligned next pointer
	logic [W-1:0] arga_q;         // First address or target
	logic [W-1:0] argb_q;         // Second address
	logic [W-1:0] latch_q;        // Last word read
	seq_state_e   seq_q;          // Sequencer state
	seq_state_e   seq_d;          // Next sequencer state
	logic [3:0]   op_q;           // Running opcode
	logic [3:0]   dst_q;          // Running destination
	logic         byte_q;         // Running byte flag
	logic         busy;           // Memory sequence running
	logic         setup;          // APB setup cycle
	logic         acc;            // APB completing access
	logic         wr_ok;          // Accepted write
	logic         wr_reg;         // Accepted register write
	logic         cmd_go;         // Accepted command
	logic         refuse;         // Access to be refused
	logic         bad_cmd;        // Malformed command
	logic         is_reg;         // Address hits register array
	logic [3:0]   wr_idx;         // Register index from address
	logic [W-1:0] merged;         // Register with byte lanes applied
	logic [DW-1:0] rd_word;       // Read data being selected
	logic [3:0]   cmd_op;         // Command opcode field
	logic [3:0]   cmd_dst;        // Command destination field
	logic [3:0]   cmd_src;        // Command source field
	logic         cmd_byte;       // Command byte flag
	logic [1:0]   cmd_len;        // Command step length
	logic [W-1:0] step_bytes;     // Step length in bytes
	logic         port_start;     // Launch memory access
	logic         port_we;        // Access is a write
	logic         port_byte;      // Access is a byte
	logic [W-1:0] port_addr;      // Access address
	logic [W-1:0] port_wdata;     // Access write data
	logic         port_done;      // Access finished
	logic [W-1:0] port_rdata;     // Access read data

	// Bus phase and command field decode
	assign setup      = psel && !penable;
	assign acc        = psel && penable && pready;
	assign wr_ok      = acc && pwrite && !pslverr;
	assign is_reg     = paddr < REG_SPAN;
	assign wr_idx     = paddr[5:2];
	assign wr_reg     = wr_ok && is_reg;
	assign cmd_go     = wr_ok && (paddr == OFF_CMD);
	assign busy       = seq_q != ST_IDLE;
	assign cmd_op     = pwdata[OP_LSB +: 4];
	assign cmd_dst    = pwdata[DST_LSB +: 4];
	assign cmd_src    = pwdata[SRC_LSB +: 4];
	assign cmd_byte   = pwdata[BYTE_BIT];
	assign cmd_len    = pwdata[LEN_LSB +: 2];
	assign step_bytes = {{(W-3){1'b0}}, cmd_len, 1'b0};

	// Command legality check
	always_comb begin
		bad_cmd = 1'b0;
		case (cmd_op)
			OP_NONE, OP_PUSH, OP_POP, OP_CALL, OP_IRQ, OP_STORE, OP_MEMMOV: begin
				bad_cmd = 1'b0;
			end
			OP_STEP: begin
				bad_cmd = cmd_len == LEN_NONE;
			end
			OP_MOVR, OP_LOAD: begin
				bad_cmd = cmd_byte && (cmd_dst == IDX_SR);
			end
			default: begin
				bad_cmd = 1'b1;
			end
		endcase
	end

	// Address decode, refusal and read data
	always_comb begin
		refuse  = 1'b0;
		rd_word = {DW{1'b0}};
		if (paddr[1:0] != 2'b00) begin
			refuse = 1'b1;
		end else if (is_reg) begin
			// Status flags take whole words only
			refuse  = pwrite && (busy || (wr_idx == IDX_SR && pstrb[1:0] != LOW_LANES));
			rd_word = {PAD_ZERO, regs_q[wr_idx]};
		end else if (paddr == OFF_CMD) begin
			refuse  = pwrite && (busy || bad_cmd);
			// Fields read back where they were written: op, destination, byte flag
			rd_word = {PAD_ZERO, 3'b000, byte_q, 4'h0, dst_q, op_q};
		end else if (paddr == OFF_ARGA) begin
			refuse  = pwrite && busy;
			rd_word = {PAD_ZERO, arga_q};
		end else if (paddr == OFF_ARGB) begin
			refuse  = pwrite && busy;
			rd_word = {PAD_ZERO, argb_q};
		end else if (paddr == OFF_STAT) begin
			refuse  = pwrite;
			rd_word = {PAD_ZERO, 12'h000, seq_q, busy};
		end else if (paddr == OFF_LATCH) begin
			refuse  = pwrite;
			rd_word = {PAD_ZERO, latch_q};
		end else begin
			refuse = 1'b1;
		end
	end

	// APB answer, one access cycle for every transfer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= {DW{1'b0}};
		end else begin
			pready  <= setup;
			pslverr <= setup && refuse;
			if (setup && !pwrite)
				prdata <= rd_word;
		end
	end

	// Byte lane merge for register writes
	always_comb begin
		merged = regs_q[wr_idx];
		if (pstrb[0])
			merged[7:0] = pwdata[7:0];
		if (pstrb[1])
			merged[15:8] = pwdata[15:8];
	end

	// Next register values from bus, commands and memory returns
	always_comb begin
		regs_d = regs_q;
		if (wr_reg) begin
			// Counter write is a branch
			regs_d[wr_idx] = merged;
		end else if (cmd_go) begin
			case (cmd_op)
				OP_STEP: begin
					regs_d[IDX_PC] = regs_q[IDX_PC] + step_bytes;
				end
				OP_MOVR: begin
					// Finishes in the accepting cycle
					regs_d[cmd_dst] = cmd_byte ? {BYTE_ZERO, regs_q[cmd_src][7:0]} : regs_q[cmd_src];
				end
				OP_PUSH: begin
					regs_d[IDX_SP] = regs_q[IDX_SP] - WORD_STEP;
				end
				OP_CALL, OP_IRQ: begin
					regs_d[IDX_SP] = regs_q[IDX_SP] - WORD_STEP;
					regs_d[IDX_PC] = arga_q;
				end
				default: begin
					regs_d = regs_q;
				end
			endcase
		end else if (port_done && seq_q == ST_WRITE2) begin
			// Second push of an interrupt entry
			regs_d[IDX_SP] = regs_q[IDX_SP] - WORD_STEP;
		end else if (port_done && seq_q == ST_READ) begin
			if (op_q == OP_POP) begin
				regs_d[dst_q] = port_rdata;
				if (dst_q != IDX_SP)
					regs_d[IDX_SP] = regs_q[IDX_SP] + WORD_STEP;
			end else if (op_q == OP_LOAD) begin
				regs_d[dst_q] = port_rdata;
			end
		end
	end

	// Counter and pointer always land on even addresses
	even_align #(
		.WIDTH (W)
	) u_pc_align (
		.d (regs_d[IDX_PC]),
		.q (pc_even)
	);

	even_align #(
		.WIDTH (W)
	) u_sp_align (
		.d (regs_d[IDX_SP]),
		.q (sp_even)
	);

	// Register array storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NREG; i++)
				regs_q[i] <= RESET_WORD;
		end else begin
			regs_q[IDX_PC] <= pc_even;
			regs_q[IDX_SP] <= sp_even;
			// Upper registers are plain storage
			for (int i = 2; i < NREG; i++)
				regs_q[i] <= regs_d[i];
		end
	end

	// Command arguments held by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arga_q <= RESET_WORD;
			argb_q <= RESET_WORD;
		end else if (wr_ok) begin
			if (paddr == OFF_ARGA)
				arga_q <= pwdata[W-1:0];
			else if (paddr == OFF_ARGB)
				argb_q <= pwdata[W-1:0];
		end
	end

	// Running command fields and data latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_q    <= OP_NONE;
			dst_q   <= IDX_PC;
			byte_q  <= 1'b0;
			latch_q <= RESET_WORD;
		end else begin
			if (cmd_go) begin
				op_q   <= cmd_op;
				dst_q  <= cmd_dst;
				byte_q <= cmd_byte;
			end
			// Moved word stays out of the register array
			if (port_done && seq_q == ST_READ)
				latch_q <= port_rdata;
		end
	end

	// Memory access launches
	always_comb begin
		port_start = 1'b0;
		port_we    = 1'b0;
		port_byte  = 1'b0;
		port_addr  = regs_q[IDX_SP] - WORD_STEP;
		port_wdata = regs_q[IDX_PC];
		if (cmd_go) begin
			case (cmd_op)
				OP_PUSH: begin
					// Old value leaves, even for the pointer itself
					port_start = 1'b1;
					port_we    = 1'b1;
					port_wdata = regs_q[cmd_src];
				end
				OP_CALL, OP_IRQ: begin
					port_start = 1'b1;
					port_we    = 1'b1;
				end
				OP_POP: begin
					port_start = 1'b1;
					port_addr  = regs_q[IDX_SP];
				end
				OP_LOAD, OP_MEMMOV: begin
					port_start = 1'b1;
					port_byte  = cmd_byte;
					port_addr  = arga_q;
				end
				OP_STORE: begin
					port_start = 1'b1;
					port_we    = 1'b1;
					port_byte  = cmd_byte;
					port_addr  = arga_q;
					port_wdata = regs_q[cmd_src];
				end
				default: begin
					port_start = 1'b0;
				end
			endcase
		end else if (port_done && seq_q == ST_WRITE2) begin
			// Flags follow the return address
			port_start = 1'b1;
			port_we    = 1'b1;
			port_wdata = regs_q[IDX_SR];
		end else if (port_done && seq_q == ST_READ && op_q == OP_MEMMOV) begin
			port_start = 1'b1;
			port_we    = 1'b1;
			port_byte  = byte_q;
			port_addr  = argb_q;
			port_wdata = port_rdata;
		end
	end

	// Sequencer next state
	always_comb begin
		seq_d = seq_q;
		case (seq_q)
			ST_IDLE: begin
				if (cmd_go) begin
					if (cmd_op == OP_PUSH || cmd_op == OP_CALL || cmd_op == OP_STORE)
						seq_d = ST_WRITE;
					else if (cmd_op == OP_IRQ)
						seq_d = ST_WRITE2;
					else if (cmd_op == OP_POP || cmd_op == OP_LOAD || cmd_op == OP_MEMMOV)
						seq_d = ST_READ;
				end
			end
			ST_READ: begin
				if (port_done)
					seq_d = (op_q == OP_MEMMOV) ? ST_WRITE : ST_IDLE;
			end
			ST_WRITE2: begin
				if (port_done)
					seq_d = ST_WRITE;
			end
			ST_WRITE: begin
				if (port_done)
					seq_d = ST_IDLE;
			end
			default: begin
				seq_d = ST_IDLE;
			end
		endcase
	end

	// Sequencer state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			seq_q <= ST_IDLE;
		else
			seq_q <= seq_d;
	end

	// Memory bus master
	mem_port u_mem_port (
		.pclk      (pclk),
		.presetn   (presetn),
		.start     (port_start),
		.we        (port_we),
		.byte_op   (port_byte),
		.addr      (port_addr),
		.wdata     (port_wdata),
		.done      (port_done),
		.rdata     (port_rdata),
		.mem_req   (mem_req),
		.mem_we    (mem_we),
		.mem_addr  (mem_addr),
		.mem_wdata (mem_wdata),
		.mem_ben   (mem_ben),
		.mem_rdata (mem_rdata),
		.mem_ack   (mem_ack)
	);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_push_go;
		cmd_go && cmd_op == OP_PUSH;
	endsequence

	sequence s_call_go;
		cmd_go && (cmd_op == OP_CALL || cmd_op == OP_IRQ);
	endsequence

	sequence s_pop_back;
		port_done && seq_q == ST_READ && op_q == OP_POP;
	endsequence

	sequence s_move_read;
		port_done && seq_q == ST_READ && op_q == OP_MEMMOV;
	endsequence

	a_push_predec: assert property (s_push_go |=>
		regs_q[IDX_SP] == $past(regs_q[IDX_SP]) - WORD_STEP && mem_addr == regs_q[IDX_SP])
		else $error("push did not predecrement");

	a_push_old_value: assert property (s_push_go |=> mem_req && mem_wdata == $past(regs_q[cmd_src]))
		else $error("push wrote wrong value");

	a_pop_postinc: assert property (s_pop_back ##0 (dst_q != IDX_SP) |=>
		regs_q[IDX_SP] == $past(regs_q[IDX_SP]) + WORD_STEP)
		else $error("pop did not postincrement");

	a_pop_self: assert property (s_pop_back ##0 (dst_q == IDX_SP) |=>
		regs_q[IDX_SP] == {$past(port_rdata[W-1:1]), 1'b0})
		else $error("popped pointer wrong");

	a_step_length: assert property (cmd_go && cmd_op == OP_STEP |=>
		regs_q[IDX_PC] == $past(regs_q[IDX_PC]) + $past(step_bytes))
		else $error("counter step wrong");

	a_align_even: assert property (regs_q[IDX_PC][0] == 1'b0 && regs_q[IDX_SP][0] == 1'b0)
		else $error("counter or pointer odd");

	a_branch_write: assert property (wr_reg && wr_idx == IDX_PC && pstrb == ALL_LANES |=>
		regs_q[IDX_PC] == {$past(pwdata[W-1:1]), 1'b0})
		else $error("branch write lost");

	a_move_single: assert property (cmd_go && cmd_op == OP_MOVR && !cmd_byte && cmd_dst > IDX_SP |=>
		regs_q[$past(cmd_dst)] == $past(regs_q[cmd_src]))
		else $error("register move late");

	a_call_save: assert property (s_call_go |=> mem_req && mem_we && mem_wdata == $past(regs_q[IDX_PC]))
		else $error("return address not pushed");

	a_copy_mem: assert property (s_move_read |=> mem_req && mem_we && mem_addr == argb_q)
		else $error("memory move write missing");

	a_flags_word: assert property (setup && pwrite && is_reg && wr_idx == IDX_SR && pstrb[1:0] != LOW_LANES
		|=> pslverr)
		else $error("byte write to flags accepted");
endmodule

// ==== common/regfile_pkg.sv ====
// Constants, register map and sequencer states of the register file
// Overview of operation
// - Sixteen 16-bit registers, all software visible
// - Registers 0-2 special, 3-15 plain working
// - Program counter steps by two, four, six
// - Program counter bit zero always cleared
// - Writing the program counter branches there
// - Calls and interrupts push return address
// - Push predecrements; pop reads then postincrements
// - Stack pointer set by software, kept even
// - Pushing stack pointer still decrements it
// - Popping stack pointer loads word, no increment
// - Flat 16-bit address bus, no paging
// - Register-only operation takes one cycle
// - Memory-to-memory move without general register
// - Byte and word memory accesses supported
// - Register two writable by whole words only
package regfile_pkg;
	localparam int              W          = 16;       // Register and bus width
	localparam int              NREG       = 16;       // Number of registers
	localparam int              AW         = 8;        // APB address width
	localparam int              DW         = 32;       // APB data width
	localparam logic [3:0]      IDX_PC     = 4'h0;     // Program counter index
	localparam logic [3:0]      IDX_SP     = 4'h1;     // Stack pointer index
	localparam logic [3:0]      IDX_SR     = 4'h2;     // Status flags index
	localparam logic [AW-1:0]   REG_SPAN   = 8'h40;    // Registers sit below this
	localparam logic [AW-1:0]   OFF_CMD    = 8'h40;    // Command register
	localparam logic [AW-1:0]   OFF_ARGA   = 8'h44;    // First address or target
	localparam logic [AW-1:0]   OFF_ARGB   = 8'h48;    // Second address
	localparam logic [AW-1:0]   OFF_STAT   = 8'h4c;    // Status
	localparam logic [AW-1:0]   OFF_LATCH  = 8'h50;    // Last word read from memory
	localparam logic [W-1:0]    WORD_STEP  = 16'h0002; // One word in bytes
	localparam logic [W-1:0]    RESET_WORD = 16'h0000; // Register reset value
	localparam logic [7:0]      BYTE_ZERO  = 8'h00;    // Cleared upper byte
	localparam logic [DW-W-1:0] PAD_ZERO   = 16'h0000; // Unused read bits
	localparam logic [3:0]      ALL_LANES  = 4'hf;     // Full word strobe
	localparam logic [1:0]      LOW_LANES  = 2'h3;     // Both register byte lanes
	localparam logic [1:0]      BEN_WORD   = 2'h3;     // Memory word enables
	localparam logic [1:0]      BEN_LO     = 2'h1;     // Memory even byte
	localparam logic [1:0]      BEN_HI     = 2'h2;     // Memory odd byte
	localparam int              OP_LSB     = 0;        // Command opcode field
	localparam int              DST_LSB    = 4;        // Destination register field
	localparam int              SRC_LSB    = 8;        // Source register field
	localparam int              BYTE_BIT   = 12;       // Byte operation flag
	localparam int              LEN_LSB    = 13;       // Step length in words
	localparam logic [3:0]      OP_NONE    = 4'h0;     // No operation
	localparam logic [3:0]      OP_STEP    = 4'h1;     // Advance program counter
	localparam logic [3:0]      OP_PUSH    = 4'h2;     // Push source register
	localparam logic [3:0]      OP_POP     = 4'h3;     // Pop into destination
	localparam logic [3:0]      OP_CALL    = 4'h4;     // Push counter, branch
	localparam logic [3:0]      OP_IRQ     = 4'h5;     // Push counter and flags
	localparam logic [3:0]      OP_MOVR    = 4'h6;     // Register to register
	localparam logic [3:0]      OP_LOAD    = 4'h7;     // Memory to register
	localparam logic [3:0]      OP_STORE   = 4'h8;     // Register to memory
	localparam logic [3:0]      OP_MEMMOV  = 4'h9;     // Memory to memory
	localparam logic [1:0]      LEN_NONE   = 2'h0;     // Illegal step length
	// Memory sequencer states, Gray on every step except between ST_IDLE and ST_WRITE
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_READ   = 3'b001,
		ST_WRITE  = 3'b011,
		ST_WRITE2 = 3'b010
	} seq_state_e;
endpackage

// ==== rtl/even_align.sv ====
// Forces the lowest bit of a word to zero
`timescale 1ns/1ns
module even_align #(
	parameter int WIDTH = 16
) (
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	// Keep upper bits, clear bit zero
	assign q = {d[WIDTH-1:1], 1'b0};
endmodule

// ==== rtl/mem_port.sv ====
// Single-access memory master port with byte lane handling
`timescale 1ns/1ns
module mem_port (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  start,
	input  wire logic                  we,
	input  wire logic                  byte_op,
	input  wire logic [regfile_pkg::W-1:0] addr,
	input  wire logic [regfile_pkg::W-1:0] wdata,
	output logic                       done,
	output logic      [regfile_pkg::W-1:0] rdata,
	output logic                       mem_req,
	output logic                       mem_we,
	output logic      [regfile_pkg::W-1:0] mem_addr,
	output logic      [regfile_pkg::W-1:0] mem_wdata,
	output logic      [1:0]            mem_ben,
	input  wire logic [regfile_pkg::W-1:0] mem_rdata,
	input  wire logic                  mem_ack
);
	import regfile_pkg::*;

	// Request held until acknowledged, then dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_req   <= 1'b0;
			mem_we    <= 1'b0;
			mem_addr  <= RESET_WORD;
			mem_wdata <= RESET_WORD;
			mem_ben   <= BEN_WORD;
		end else if (start) begin
			mem_req   <= 1'b1;
			mem_we    <= we;
			mem_addr  <= addr;
			// Byte data rides on both lanes
			mem_wdata <= byte_op ? {wdata[7:0], wdata[7:0]} : wdata;
			mem_ben   <= !byte_op ? BEN_WORD : (addr[0] ? BEN_HI : BEN_LO);
		end else if (mem_req && mem_ack) begin
			mem_req <= 1'b0;
		end
	end

	// Completion pulse and lane-selected read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done  <= 1'b0;
			rdata <= RESET_WORD;
		end else begin
			done <= mem_req && mem_ack;
			if (mem_req && mem_ack && !mem_we) begin
				if (mem_ben == BEN_HI)
					rdata <= {BYTE_ZERO, mem_rdata[15:8]};
				else if (mem_ben == BEN_LO)
					rdata <= {BYTE_ZERO, mem_rdata[7:0]};
				else
					rdata <= mem_rdata;
			end
		end
	end
endmodule

// ==== dv/mem_model.sv ====
// Behavioural program and data memory with prompt or slow answers
`timescale 1ns/1ns
module mem_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        slow,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [15:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	input  wire logic [1:0]  mem_ben,
	output logic      [15:0] mem_rdata,
	output logic             mem_ack
);
	logic [15:0] mem [0:255]; // Word store, address bits 8:1 select
	logic [2:0]  cnt;         // Wait cycles spent on this request
	logic [7:0]  idx;         // Word index of the request
	assign idx = mem_addr[8:1]; // Upper address bits alias, all 16 are driven
	// Answer after zero or three waits; read data toggles when not answering
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ack   <= 1'b0;
			cnt       <= 3'h0;
			mem_rdata <= 16'h0000;
		end else if (mem_req && !mem_ack && (!slow || cnt == 3'h3)) begin
			mem_ack   <= 1'b1;
			cnt       <= 3'h0;
			mem_rdata <= mem[idx];
			// Byte lanes written only where enabled
			if (mem_we && mem_ben[0]) mem[idx][7:0] <= mem_wdata[7:0];
			if (mem_we && mem_ben[1]) mem[idx][15:8] <= mem_wdata[15:8];
		end else begin
			mem_ack   <= 1'b0;
			cnt       <= mem_req ? cnt + 3'h1 : 3'h0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule

// ==== dv/test_cpu_pc_sp_register_file.sv ====
// Self-checking bench for the register file and its memory sequencer
`timescale 1ns/1ns
module test_cpu_pc_sp_register_file;
	import regfile_pkg::*;
	logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, err;
	logic [AW-1:0] paddr;
	logic [DW-1:0] pwdata, prdata, rd;
	logic [3:0]    pstrb;
	logic          mem_req, mem_we, mem_ack;
	logic [W-1:0]  mem_addr, mem_wdata, mem_rdata, last_addr, pc;
	logic [1:0]    mem_ben;
	int            fails, n_checks;

	cpu_pc_sp_register_file u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.pready, .prdata, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ben, .mem_rdata, .mem_ack);
	mem_model u_mem (.pclk, .presetn, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ben,
		.mem_rdata, .mem_ack);

	// Clock of 4 ns
	initial pclk = 1'b0;
	always #2 pclk = ~pclk;
	// Address of the last completed memory access
	always @(posedge pclk) if (mem_req && mem_ack) last_addr <= mem_addr;

	// Counts and verdict, then stop
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Compare seen against expected
	task automatic chk(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One APB transfer; result kept in rd and err
	task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		pstrb  <= s;
		@(posedge pclk);
		penable <= 1'b1;
		// Access phase holds until pready is seen high at a rising edge
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd  = prdata;
		err = pslverr;
		if (n >= 20) chk("pready", 32'h0, 32'h1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		apb(1'b1, a, d, ALL_LANES);
	endtask
	task automatic rdchk(input string what, input logic [AW-1:0] a, input logic [DW-1:0] exp);
		apb(1'b0, a, 32'h0, 4'h0);
		chk(what, rd, exp);
	endtask
	// Issue a command and wait until the sequencer is idle
	task automatic run(input logic [DW-1:0] c);
		int n;
		wr(OFF_CMD, c);
		n = 0;
		do begin
			apb(1'b0, OFF_STAT, 32'h0, 4'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 50);
		chk("busy", {31'h0, rd[0]}, 32'h0);
	endtask
	function automatic logic [DW-1:0] cmd(input logic [3:0] op, input logic [3:0] dst, input logic [3:0] src,
		input logic b, input logic [1:0] len);
		cmd = {17'h0, len, b, src, dst, op};
	endfunction
	function automatic logic [7:0] mi(input logic [15:0] a);
		mi = a[8:1];
	endfunction

	// Watchdog
	initial begin
		#100000;
		fails++;
		close_out();
	end
	// Main sequence
	initial begin
		{psel, penable, pwrite, slow} = 4'h0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		pstrb   = 4'h0;
		presetn = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 16; i++) rdchk("reset reg", 8'(4 * i), 32'h0);
		$display("test reset done");
		for (int i = 0; i < 16; i++) wr(8'(4 * i), 32'h5a5a_0000 | (16'h8001 + 16'(i * 514)));
		for (int i = 0; i < 16; i++)
			rdchk("reg", 8'(4 * i), {16'h0, (16'h8001 + 16'(i * 514)) & (i < 2 ? 16'hfffe : 16'hffff)});
		$display("test registers done");
		apb(1'b1, 8'h08, 32'h0001, 4'h1);
		chk("part write reg two err", {31'h0, err}, 32'h1);
		rdchk("reg two kept", 8'h08, 32'h0000_8405);
		apb(1'b1, 8'h06, 32'h0001, ALL_LANES);
		chk("unaligned err", {31'h0, err}, 32'h1);
		$display("test refusals done");
		wr(8'h00, 32'h1000);
		pc = 16'h1000;
		for (int l = 1; l < 4; l++) begin
			wr(OFF_CMD, cmd(OP_STEP, 4'h0, 4'h0, 1'b0, 2'(l)));
			pc = pc + 16'(2 * l);
			rdchk("pc step", 8'h00, {16'h0, pc});
		end
		apb(1'b1, OFF_CMD, cmd(OP_STEP, 4'h0, 4'h0, 1'b0, LEN_NONE), ALL_LANES);
		chk("step zero err", {31'h0, err}, 32'h1);
		rdchk("pc kept", 8'h00, {16'h0, pc});
		$display("test step done");
		slow <= 1'b1;
		wr(8'h04, 32'h0200);
		wr(8'h14, 32'hbeef);
		run(cmd(OP_PUSH, 4'h0, 4'h5, 1'b0, 2'h1));
		rdchk("sp push", 8'h04, 32'h01fe);
		chk("pushed word", {16'h0, u_mem.mem[mi(16'h01fe)]}, 32'hbeef);
		run(cmd(OP_POP, 4'h6, 4'h0, 1'b0, 2'h1));
		rdchk("popped reg", 8'h18, 32'hbeef);
		rdchk("sp pop", 8'h04, 32'h0200);
		run(cmd(OP_PUSH, 4'h0, 4'h1, 1'b0, 2'h1));
		rdchk("sp push sp", 8'h04, 32'h01fe);
		chk("pushed sp", {16'h0, u_mem.mem[mi(16'h01fe)]}, 32'h0200);
		u_mem.mem[mi(16'h01fe)] = 16'h0340;
		run(cmd(OP_POP, 4'h1, 4'h0, 1'b0, 2'h1));
		rdchk("sp pop sp", 8'h04, 32'h0340);
		wr(OFF_CMD, cmd(OP_MOVR, 4'h9, 4'h5, 1'b0, 2'h1));
		rdchk("move word", 8'h24, 32'hbeef);
		rdchk("cmd readback", OFF_CMD, 32'h0096);
		wr(OFF_CMD, cmd(OP_MOVR, 4'ha, 4'h9, 1'b1, 2'h1));
		rdchk("move byte", 8'h28, 32'h00ef);
		apb(1'b1, OFF_CMD, cmd(OP_MOVR, IDX_SR, 4'h5, 1'b1, 2'h1), ALL_LANES);
		chk("byte to flags err", {31'h0, err}, 32'h1);
		rdchk("flags kept", 8'h08, 32'h0000_8405);
		$display("test stack done");
		slow <= 1'b0;
		wr(8'h04, 32'h0200);
		wr(8'h00, 32'h1234);
		wr(OFF_ARGA, 32'h4000);
		run(cmd(OP_CALL, 4'h0, 4'h0, 1'b0, 2'h1));
		rdchk("pc call", 8'h00, 32'h4000);
		rdchk("sp call", 8'h04, 32'h01fe);
		chk("return addr", {16'h0, u_mem.mem[mi(16'h01fe)]}, 32'h1234);
		wr(8'h04, 32'h0200);
		wr(8'h00, 32'h2222);
		wr(8'h08, 32'h0105);
		wr(OFF_ARGA, 32'h5000);
		run(cmd(OP_IRQ, 4'h0, 4'h0, 1'b0, 2'h1));
		rdchk("pc irq", 8'h00, 32'h5000);
		rdchk("sp irq", 8'h04, 32'h01fc);
		chk("irq pc", {16'h0, u_mem.mem[mi(16'h01fe)]}, 32'h2222);
		chk("irq flags", {16'h0, u_mem.mem[mi(16'h01fc)]}, 32'h0105);
		$display("test call done");
		u_mem.mem[mi(16'h0010)] = 16'h5a5a;
		wr(OFF_ARGA, 32'h0010);
		wr(OFF_ARGB, 32'h0020);
		run(cmd(OP_MEMMOV, 4'h0, 4'h0, 1'b0, 2'h1));
		chk("copied word", {16'h0, u_mem.mem[mi(16'h0020)]}, 32'h5a5a);
		rdchk("reg four kept", 8'h10, 32'h8809);
		u_mem.mem[mi(16'h0030)] = 16'h12ab;
		wr(OFF_ARGA, 32'h8031);
		run(cmd(OP_LOAD, 4'h7, 4'h0, 1'b1, 2'h1));
		rdchk("byte load", 8'h1c, 32'h0012);
		chk("full address", {16'h0, last_addr}, 32'h8031);
		wr(8'h1c, 32'h00cd);
		run(cmd(OP_STORE, 4'h0, 4'h7, 1'b1, 2'h1));
		chk("byte store", {16'h0, u_mem.mem[mi(16'h0030)]}, 32'hcdab);
		wr(OFF_ARGA, 32'h8030);
		run(cmd(OP_LOAD, 4'h8, 4'h0, 1'b0, 2'h1));
		rdchk("word load", 8'h20, 32'hcdab);
		$display("test memory done");
		close_out();
	end
endmodule
